// ===== logic/pocd_top.sv
// paired output clock divider: two channels, wishbone register file, sync handling
//
// Function
// R1: low phase lasts low count plus one
// R2: high phase lasts high count plus one
// R3: bypass powers divider down, passes input clock
// R4: channel 0 resets bypassed, channel 1 not
// R5: nosync clear obeys chip sync, set ignores
// R6: software sets nosync before using force level
// R7: force bit picks static low or high
// R8: start bit picks waveform starting level
// R9: four-bit phase offset per channel, reset zero
// R10: direct bit clear feeds pair from divider
// R11: direct bit set routes per source select
// R12: duty fix disable bit, clear enables correction
// R13: two identical channels at their register offsets
// R14: second routing register mirrors first channel bits
// R15: sync restarts counters, start level, then phase
//
// The Wishbone register port was decided locally.
`include "pocd_defs.svh"

module pocd_top #(
    parameter int NUM_CH = 2,
    parameter int CNT_W  = 4
) (
    input  wire logic        clk_i,      // divider input clock
    input  wire logic        rst_i,      // synchronous reset, active high
    input  wire logic [11:0] adr_i,      // wishbone byte address
    input  wire logic [31:0] dat_i,      // wishbone write data
    output logic      [31:0] dat_o,      // wishbone read data
    input  wire logic [3:0]  sel_i,      // wishbone byte lanes
    input  wire logic        we_i,       // wishbone write enable
    input  wire logic        cyc_i,      // wishbone cycle
    input  wire logic        stb_i,      // wishbone strobe
    output logic             ack_o,      // wishbone acknowledge
    input  wire logic        sync_n_i,   // chip-level sync pin, active low
    input  wire logic        vco_lvl_i,  // internal oscillator image
    input  wire logic        ext_lvl_i,  // external clock input image
    output logic             pair_a_first_output_o,   // channel 0 first output
    output logic             pair_a_second_output_o,  // channel 0 second output
    output logic             pair_b_first_output_o,   // channel 1 first output
    output logic             pair_b_second_output_o,  // channel 1 second output
    output logic [1:0]       duty_fix_en_o,  // duty correction enable per channel
    output logic [1:0]       div_pwrdn_o     // divider logic powered down per channel
);

    // unsupported sizes are refused while the design is built, not at run time
    if (NUM_CH != 2) begin : g_bad_num_ch
        $error("pocd_top: register map serves exactly two channels");
    end
    if (CNT_W != 4) begin : g_bad_cnt_w
        $error("pocd_top: count fields are four bits wide");
    end

    // register storage
    logic [7:0] cnt_reg   [NUM_CH];
    logic [7:0] ctrl_reg  [NUM_CH];
    logic [7:0] route_reg [NUM_CH];
    logic [1:0] src_sel;

    // divider state
    pocd_pkg::pocd_state_t state [NUM_CH];
    logic [CNT_W-1:0]      cnt   [NUM_CH];
    logic [CNT_W-1:0]      phase [NUM_CH];
    logic [NUM_CH-1:0]     level;
    logic [NUM_CH-1:0]     out_q;
    logic                  clk_img;

    // synchronisers
    logic [`POCD_SYNC_STAGES-1:0] sync_ff;
    logic [`POCD_SYNC_STAGES-1:0] vco_ff;
    logic [`POCD_SYNC_STAGES-1:0] ext_ff;
    logic                         sync_active;
    logic                         vco_lvl;
    logic                         ext_lvl;

    // bus decode
    logic       bus_req;
    logic       wr_stb;
    logic [9:0] idx;

    function automatic logic idx_is(input logic [9:0] a, input logic [9:0] b);
        return a == b;
    endfunction

    function automatic pocd_pkg::pocd_path_t path_of(input logic [7:0] route,
                                                     input logic [1:0] sel);
        pocd_pkg::pocd_path_t p;
        p = pocd_pkg::POCD_PATH_DIV;
        if (route[`POCD_BIT_DIRECT]) begin                       // see R10
            case (sel)                                           // see R11
                `POCD_SRC_VCO: p = pocd_pkg::POCD_PATH_VCO;
                `POCD_SRC_EXT: p = pocd_pkg::POCD_PATH_EXT;
                default:       p = pocd_pkg::POCD_PATH_DIV;
            endcase
        end
        return p;
    endfunction

    // limit of the count for the level now shown
    function automatic logic [CNT_W-1:0] limit_of(input logic [7:0] counts,
                                                  input logic       lvl);
        return lvl ? counts[`POCD_HIGH_MSB:`POCD_HIGH_LSB]       // see R2
                   : counts[`POCD_LOW_MSB:`POCD_LOW_LSB];        // see R1
    endfunction

    assign bus_req = cyc_i && stb_i;
    assign wr_stb  = bus_req && we_i && sel_i[0] && !ack_o;
    assign idx     = adr_i[11:2];

    // two flops before any logic looks at the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_ff <= '1;
            vco_ff  <= '0;
            ext_ff  <= '0;
        end else begin
            sync_ff <= {sync_ff[0], sync_n_i};
            vco_ff  <= {vco_ff[0], vco_lvl_i};
            ext_ff  <= {ext_ff[0], ext_lvl_i};
        end
    end

    assign sync_active = !sync_ff[`POCD_SYNC_STAGES-1];
    assign vco_lvl     = vco_ff[`POCD_SYNC_STAGES-1];
    assign ext_lvl     = ext_ff[`POCD_SYNC_STAGES-1];

    // wishbone acknowledge, one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req && !ack_o;
        end
    end

    // register writes; unmapped indexes are acked and ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg[0]   <= `POCD_RST_CNT;
            cnt_reg[1]   <= `POCD_RST_CNT;
            ctrl_reg[0]  <= `POCD_RST_CTRL0;                     // see R4
            ctrl_reg[1]  <= `POCD_RST_CTRL1;                     // see R4
            route_reg[0] <= `POCD_RST_ROUTE;
            route_reg[1] <= `POCD_RST_ROUTE;                     // see R14
            src_sel      <= `POCD_RST_SRCSEL;
        end else if (wr_stb) begin
            if (idx_is(idx, `POCD_IDX_CNT0)) begin               // see R13
                cnt_reg[0] <= dat_i[7:0];
            end
            if (idx_is(idx, `POCD_IDX_CTRL0)) begin
                ctrl_reg[0] <= dat_i[7:0];
            end
            if (idx_is(idx, `POCD_IDX_ROUTE0)) begin
                route_reg[0] <= {6'h00, dat_i[1:0]};
            end
            if (idx_is(idx, `POCD_IDX_CNT1)) begin               // see R13
                cnt_reg[1] <= dat_i[7:0];
            end
            if (idx_is(idx, `POCD_IDX_CTRL1)) begin
                ctrl_reg[1] <= dat_i[7:0];
            end
            if (idx_is(idx, `POCD_IDX_ROUTE1)) begin             // see R14
                route_reg[1] <= {6'h00, dat_i[1:0]};
            end
            if (idx_is(idx, `POCD_IDX_SRCSEL)) begin
                src_sel <= dat_i[1:0];
            end
        end
    end

    // read data, registered alongside ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_req && !ack_o && !we_i) begin
            case (idx)
                `POCD_IDX_CNT0:   dat_o <= {24'h000000, cnt_reg[0]};
                `POCD_IDX_CTRL0:  dat_o <= {24'h000000, ctrl_reg[0]};
                `POCD_IDX_ROUTE0: dat_o <= {24'h000000, route_reg[0]};
                `POCD_IDX_CNT1:   dat_o <= {24'h000000, cnt_reg[1]};
                `POCD_IDX_CTRL1:  dat_o <= {24'h000000, ctrl_reg[1]};
                `POCD_IDX_ROUTE1: dat_o <= {24'h000000, route_reg[1]};
                `POCD_IDX_SRCSEL: dat_o <= {30'h00000000, src_sel};
                `POCD_IDX_STATUS: dat_o <= {26'h0000000, sync_active,
                                            state[1] == pocd_pkg::POCD_PHASE,
                                            state[0] == pocd_pkg::POCD_PHASE,
                                            div_pwrdn_o[1] | div_pwrdn_o[0],
                                            out_q};
                default:          dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // image of the divider input clock, shown while bypassed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_img <= 1'b0;
        end else begin
            clk_img <= !clk_img;
        end
    end

    // divider channels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                state[c] <= pocd_pkg::POCD_HOLD;
                cnt[c]   <= '0;
                phase[c] <= '0;
                level[c] <= 1'b0;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (ctrl_reg[c][`POCD_BIT_BYPASS]) begin          // see R3
                    // powered down: counters parked, restart from start level
                    state[c] <= pocd_pkg::POCD_OFF;
                    cnt[c]   <= '0;
                    phase[c] <= '0;
                    level[c] <= ctrl_reg[c][`POCD_BIT_START];
                end else if (sync_active && !ctrl_reg[c][`POCD_BIT_NOSYNC]) begin // see R5
                    // held in sync: start level, phase reloaded
                    state[c] <= pocd_pkg::POCD_HOLD;              // see R15
                    cnt[c]   <= '0;
                    phase[c] <= ctrl_reg[c][`POCD_PHASE_MSB:`POCD_PHASE_LSB]; // see R9
                    level[c] <= ctrl_reg[c][`POCD_BIT_START];     // see R8
                end else begin
                    case (state[c])
                        pocd_pkg::POCD_OFF,
                        pocd_pkg::POCD_HOLD: begin
                            state[c] <= (phase[c] != '0) ? pocd_pkg::POCD_PHASE
                                                         : pocd_pkg::POCD_RUN;
                            cnt[c]   <= '0;
                        end
                        pocd_pkg::POCD_PHASE: begin
                            // start level held one cycle per offset step
                            phase[c] <= phase[c] - 1'b1;          // see R15
                            if (phase[c] == 4'h1) begin
                                state[c] <= pocd_pkg::POCD_RUN;
                            end
                        end
                        pocd_pkg::POCD_RUN: begin
                            if (cnt[c] >= limit_of(cnt_reg[c], level[c])) begin
                                cnt[c]   <= '0;
                                level[c] <= !level[c];
                            end else begin
                                cnt[c] <= cnt[c] + 1'b1;
                            end
                        end
                        default: begin
                            state[c] <= pocd_pkg::POCD_HOLD;
                        end
                    endcase
                end
            end
        end
    end

    // output selection; outputs are registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                case (path_of(route_reg[c], src_sel))
                    pocd_pkg::POCD_PATH_VCO: out_q[c] <= vco_lvl;  // see R11
                    pocd_pkg::POCD_PATH_EXT: out_q[c] <= ext_lvl;  // see R11
                    default: begin
                        if (ctrl_reg[c][`POCD_BIT_BYPASS]) begin
                            out_q[c] <= clk_img;                   // see R3
                        end else if (ctrl_reg[c][`POCD_BIT_NOSYNC] && sync_active) begin
                            // static level only means something while sync is ignored
                            out_q[c] <= ctrl_reg[c][`POCD_BIT_FORCE]; // see R6 R7
                        end else begin
                            out_q[c] <= level[c];                  // see R10
                        end
                    end
                endcase
            end
        end
    end

    assign pair_a_first_output_o  = out_q[0];
    assign pair_a_second_output_o = out_q[0];
    assign pair_b_first_output_o  = out_q[1];
    assign pair_b_second_output_o = out_q[1];

    // correction is on while the disable bit is clear
    assign duty_fix_en_o[0] = !route_reg[0][`POCD_BIT_DUTYOFF];    // see R12
    assign duty_fix_en_o[1] = !route_reg[1][`POCD_BIT_DUTYOFF];    // see R12 R14
    assign div_pwrdn_o[0]   = ctrl_reg[0][`POCD_BIT_BYPASS];
    assign div_pwrdn_o[1]   = ctrl_reg[1][`POCD_BIT_BYPASS];

endmodule

// ===== logic/pocd_defs.svh
// register indexes, field positions, reset values and timing for the divider block
`ifndef POCD_DEFS_SVH
`define POCD_DEFS_SVH

// register indexes; byte address is four times the index
`define POCD_IDX_CNT0      10'h190
`define POCD_IDX_CTRL0     10'h191
`define POCD_IDX_ROUTE0    10'h192
`define POCD_IDX_CNT1      10'h196
`define POCD_IDX_CTRL1     10'h197
`define POCD_IDX_ROUTE1    10'h198
`define POCD_IDX_SRCSEL    10'h1e1
`define POCD_IDX_STATUS    10'h1a0

// cycle count register fields
`define POCD_LOW_MSB       7
`define POCD_LOW_LSB       4
`define POCD_HIGH_MSB      3
`define POCD_HIGH_LSB      0

// control register fields
`define POCD_BIT_BYPASS    7
`define POCD_BIT_NOSYNC    6
`define POCD_BIT_FORCE     5
`define POCD_BIT_START     4
`define POCD_PHASE_MSB     3
`define POCD_PHASE_LSB     0

// routing register fields
`define POCD_BIT_DIRECT    1
`define POCD_BIT_DUTYOFF   0

// source select encodings
`define POCD_SRC_EXT       2'h0
`define POCD_SRC_NONE      2'h1
`define POCD_SRC_VCO       2'h2

// reset values
`define POCD_RST_CNT       8'h00
`define POCD_RST_CTRL0     8'h80
`define POCD_RST_CTRL1     8'h00
`define POCD_RST_ROUTE     8'h00
`define POCD_RST_SRCSEL    2'h1

// synchroniser depth for pin inputs
`define POCD_SYNC_STAGES   2

`endif

// ===== logic/pocd_pkg.sv
// types shared by the paired output clock divider
package pocd_pkg;

    // per-channel divider sequencing state
    typedef enum logic [1:0] {
        POCD_OFF,
        POCD_HOLD,
        POCD_PHASE,
        POCD_RUN
    } pocd_state_t;

    // output path choice after the routing decode
    typedef enum logic [1:0] {
        POCD_PATH_DIV,
        POCD_PATH_VCO,
        POCD_PATH_EXT
    } pocd_path_t;

endpackage

// ===== tb/pocd_checker.sv
// concurrent checks on the divider top ports
module pocd_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        we_i,
    input wire logic [3:0]  sel_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic        pair_a_first_output_o,
    input wire logic        pair_a_second_output_o,
    input wire logic        pair_b_first_output_o,
    input wire logic        pair_b_second_output_o,
    input wire logic [1:0]  duty_fix_en_o,
    input wire logic [1:0]  div_pwrdn_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_timely_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked in one cycle");
    ack_cause_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    pair_a_same_a: assert property (pair_a_first_output_o == pair_a_second_output_o)
        else $error("first pair outputs differ");
    pair_b_same_a: assert property (pair_b_first_output_o == pair_b_second_output_o)
        else $error("second pair outputs differ");
    reset_vals_a: assert property (
        $fell(rst_i) |-> duty_fix_en_o == 2'b11 && div_pwrdn_o == 2'b01)
        else $error("wrong reset state of bypass or duty fix");
    read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // config outputs may only move on an acked write
    cfg_by_write_a: assert property (
        !$past(rst_i) && $changed({duty_fix_en_o, div_pwrdn_o})
            |-> ack_o && $past(we_i && sel_i[0]))
        else $error("config output changed without a write");

    cover property (ack_o && !$past(we_i));
    cover property ($rose(div_pwrdn_o[1]));
    cover property ($rose(pair_b_first_output_o) && !div_pwrdn_o[1]);
endmodule

bind pocd_top pocd_checker pocd_checker_i (.clk_i, .rst_i, .we_i, .sel_i, .cyc_i, .stb_i,
    .ack_o, .dat_o, .pair_a_first_output_o, .pair_a_second_output_o, .pair_b_first_output_o,
    .pair_b_second_output_o, .duty_fix_en_o, .div_pwrdn_o);

// ===== tb/tb.sv
// self-checking bench for the paired output clock divider
`include "pocd_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    logic        sync_n_i = 1'b1, vco_lvl_i = 1'b0, ext_lvl_i = 1'b0, ack_o;
    logic [11:0] adr_i = 12'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [3:0]  sel_i = 4'h0, hist;
    logic        pair_a_first_output_o, pair_a_second_output_o, lv, lv2;
    logic        pair_b_first_output_o, pair_b_second_output_o;
    logic [1:0]  duty_fix_en_o, div_pwrdn_o, src_tab [4] = '{2'h2, 2'h0, 2'h1, 2'h2};
    logic [7:0]  v8, ctl_tab [5] = '{8'h10, 8'h13, 8'h60, 8'h40, 8'h50};
    int          miscompares = 0, n_compared = 0, cycles = 0, n1, n2, base;

    pocd_top pocd_top_i (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .sel_i, .we_i, .cyc_i,
        .stb_i, .ack_o, .sync_n_i, .vco_lvl_i, .ext_lvl_i, .pair_a_first_output_o,
        .pair_a_second_output_o, .pair_b_first_output_o, .pair_b_second_output_o,
        .duty_fix_en_o, .div_pwrdn_o);

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard, well above the length of the whole sequence
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic wb(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge clk_i);
        adr_i <= {idx, 2'b00};
        we_i <= wr;
        dat_i <= {24'h0, wd};
        sel_i <= 4'hf;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        // no local limit: a slave that never answers is caught by the hang guard
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    function automatic logic out_of(input bit ch);
        return ch ? pair_b_first_output_o : pair_a_first_output_o;
    endfunction

    function automatic int exp_len(input logic [7:0] c, input logic l);
        return l ? c[`POCD_HIGH_MSB:`POCD_HIGH_LSB] + 1 : c[`POCD_LOW_MSB:`POCD_LOW_LSB] + 1;
    endfunction

    // cycles until the channel output leaves its present level
    task automatic run_len(input bit ch, output int n, output logic l);
        l = out_of(ch);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (out_of(ch) === l && n < 200);
    endtask

    initial begin
        v8 = 8'($urandom(32'h9a54));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(`POCD_IDX_CTRL0, 0, 0); `CHK(rd, 32'h80)
        wb(`POCD_IDX_CTRL1, 0, 0); `CHK(rd, 32'h00)
        wb(`POCD_IDX_CNT1, 0, 0); `CHK(rd, 32'h00)
        wb(`POCD_IDX_ROUTE1, 0, 0); `CHK(rd, 32'h00)
        wb(`POCD_IDX_SRCSEL, 0, 0); `CHK(rd, 32'h1)
        wb(10'h3f0, 1, 8'hff);
        wb(10'h3f0, 0, 0); `CHK(rd, 32'h0)
        repeat (6) begin
            v8 = $urandom;
            wb(`POCD_IDX_CTRL0, 1, v8);
            wb(`POCD_IDX_CTRL0, 0, 0); `CHK(rd, {24'h0, v8})
            `CHK(div_pwrdn_o[0], v8[`POCD_BIT_BYPASS])
            wb(`POCD_IDX_ROUTE1, 1, v8);
            wb(`POCD_IDX_ROUTE1, 0, 0); `CHK(rd, {30'h0, v8[1:0]})
            `CHK(duty_fix_en_o[1], ~v8[`POCD_BIT_DUTYOFF])
            wb(`POCD_IDX_ROUTE0, 1, ~v8);
            `CHK(duty_fix_en_o[0], v8[`POCD_BIT_DUTYOFF])
        end
        wb(`POCD_IDX_ROUTE1, 1, 0);
        wb(`POCD_IDX_ROUTE0, 1, 0);
        wb(`POCD_IDX_CTRL0, 1, 0);
        wb(`POCD_IDX_CTRL1, 1, 0);
        for (int i = 0; i < 6; i++) begin
            v8 = (i == 0) ? 8'h00 : (i == 1) ? 8'hf0 : (i == 2) ? 8'h0f : 8'($urandom);
            wb(i[0] ? `POCD_IDX_CNT1 : `POCD_IDX_CNT0, 1, v8);
            run_len(i[0], n1, lv);
            run_len(i[0], n1, lv);
            run_len(i[0], n2, lv2);
            `CHK(n1, exp_len(v8, lv))
            `CHK(n2, exp_len(v8, lv2))
        end
        wb(`POCD_IDX_CNT1, 1, 0);
        for (int i = 0; i < 5; i++) begin
            wb(`POCD_IDX_CTRL1, 1, ctl_tab[i]);
            @(posedge clk_i);
            sync_n_i <= 1'b0;
            repeat (6) @(negedge clk_i);
            v8 = ctl_tab[i];
            `CHK(out_of(1), v8[6] ? v8[5] : v8[4])
            `CHK(out_of(0), 1'b0)
            @(posedge clk_i);
            sync_n_i <= 1'b1;
            run_len(1'b1, n1, lv);
            if (i == 0)
                base = n1;
            if (i == 1)
                `CHK(n1 - base, 3)
        end
        wb(`POCD_IDX_CTRL1, 1, 8'h80);
        for (int j = 0; j < 4; j++) begin
            wb(`POCD_IDX_ROUTE1, 1, (j == 3) ? 8'h00 : 8'h02);
            wb(`POCD_IDX_SRCSEL, 1, {6'h0, src_tab[j]});
            for (int k = 0; k < 16; k++) begin
                @(posedge clk_i);
                v8 = $urandom;
                vco_lvl_i <= v8[0];
                ext_lvl_i <= v8[1];
                hist = {hist[2:0], src_tab[j] == 2'h2 ? v8[0] : v8[1]};
                @(negedge clk_i);
                if (k > 4 && j < 2)
                    `CHK(out_of(1), hist[3])
                if (k > 4 && j > 1)
                    `CHK(out_of(1), ~lv)
                lv = out_of(1);
            end
        end
        report_and_stop();
    end
endmodule
